/* common/secs_pkg.sv */
// constants for the sync edge and clamp select block
// assumes one pixel-rate clock and an 8-bit register port
package secs_pkg;
  localparam int unsigned SECS_AW = 8;
  localparam int unsigned SECS_DW = 8;
  localparam int unsigned SECS_TW = 6;
  // register offsets
  localparam logic [7:0] SECS_REG_HSYNC_CFG = 8'h0E;
  localparam logic [7:0] SECS_REG_CLAMP_CFG = 8'h0F;
  localparam logic [7:0] SECS_REG_CLAMP_DLY = 8'h05;
  localparam logic [7:0] SECS_REG_CLAMP_DUR = 8'h06;
  localparam logic [7:0] SECS_REG_SLICE_THR = 8'h10;
  localparam logic [7:0] SECS_REG_STATUS = 8'h20;
  // field positions
  localparam int unsigned SECS_BIT_HSYNC_POL = 6;
  localparam int unsigned SECS_BIT_CLAMP_SEL = 7;
  localparam int unsigned SECS_BIT_CLAMP_POL = 6;
  localparam int unsigned SECS_BIT_ST_HSYNC = 0;
  localparam int unsigned SECS_BIT_ST_CLAMP = 1;
  localparam int unsigned SECS_BIT_ST_SLICE = 2;
  localparam int unsigned SECS_BIT_ST_WIN = 3;
  // reset values
  localparam logic SECS_RST_HSYNC_POL = 1'b1;
  localparam logic SECS_RST_CLAMP_SEL = 1'b0;
  localparam logic SECS_RST_CLAMP_POL = 1'b1;
  localparam logic [7:0] SECS_RST_CLAMP_DLY = 8'h08;
  localparam logic [7:0] SECS_RST_CLAMP_DUR = 8'h14;
  // threshold code is millivolts / 10
  localparam logic [5:0] SECS_THR_MIN = 6'h01;
  localparam logic [5:0] SECS_THR_MAX = 6'h21;
  localparam logic [5:0] SECS_RST_THR = 6'h0F;
  typedef enum logic [2:0] {
    SECS_IDLE = 3'b001,
    SECS_DELAY = 3'b010,
    SECS_ACTIVE = 3'b100
  } secs_clamp_state_t;
endpackage : secs_pkg

/* src/secs_clamp_gen.sv */
// internal clamp window: a delay, then a duration, from a start pulse
// assumes the start pulse marks the hsync trailing edge
`default_nettype none
module secs_clamp_gen
  import secs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_start,
  input wire logic [7:0] i_delay,
  input wire logic [7:0] i_duration,
  output logic o_window
);
  secs_clamp_state_t state_q;
  logic [7:0] cnt_q;

  // RQ12 count pixel clocks
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= SECS_IDLE;
      cnt_q <= 8'h00;
    end else if (i_start) begin
      // a fresh edge restarts the window; with zero delay an open window stays open for a new duration
      if (i_delay != 8'h00) begin
        state_q <= SECS_DELAY;
        cnt_q <= i_delay;
      end else if (i_duration != 8'h00) begin
        state_q <= SECS_ACTIVE;
        cnt_q <= i_duration;
      end else begin
        state_q <= SECS_IDLE;
        cnt_q <= 8'h00;
      end
    end else begin
      case (state_q)
        SECS_DELAY: begin
          if (cnt_q == 8'h01) begin
            state_q <= (i_duration != 8'h00) ? SECS_ACTIVE : SECS_IDLE;
            cnt_q <= i_duration;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        SECS_ACTIVE: begin
          if (cnt_q == 8'h01) begin
            state_q <= SECS_IDLE;
            cnt_q <= 8'h00;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        default: begin
          state_q <= SECS_IDLE;
          cnt_q <= 8'h00;
        end
      endcase
    end
  end

  assign o_window = (state_q == SECS_ACTIVE);

  property p_zero_delay;
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_start && i_delay == 8'h00 && i_duration != 8'h00) |=> o_window;
  endproperty
  a_zero_delay: assert property (p_zero_delay) else $error("zero delay window late"); // RQ12

  property p_delay_holds;
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_start && i_delay == 8'h02) |=> !o_window ##1 !o_window;
  endproperty
  a_delay_holds: assert property (p_delay_holds) else $error("window opened in delay"); // RQ5

  c_window: cover property (@(posedge i_clk) disable iff (!i_reset_n) $fell(o_window));
endmodule : secs_clamp_gen
`default_nettype wire

/* src/secs_top.sv */
// sync edge select, clamp source select and slicer threshold control
// assumes hsync, clamp and slicer level inputs synchronous to i_clk
//
// Function
// RQ1 - hsync logic sense follows polarity bit 6 of register 0x0E
// RQ2 - only the hsync leading edge is the timing reference
// RQ3 - polarity 0 takes falling edge as leading, 1 takes rising edge
// RQ4 - external clamp used only when bit 7 of 0x0F is 1; resets 0
// RQ5 - otherwise clamp window is internal, delay then duration after trailing edge
// RQ6 - external clamp active level follows bit 6 of register 0x0F
// RQ7 - slicer threshold steps 10 mV, from 10 mV to 330 mV
// RQ8 - slicer threshold is 150 mV after reset
// RQ9 - sliced sync output is the noninverting slicer result
// RQ10 - source drives external clamp only during the black reference
// RQ11 - unused clamp input held low with clamp select kept 0; the bench drives clamp strobes with select 0 in settings 1, 4 and 5
// RQ12 - internal clamp counters count pixel clocks from register start values
`default_nettype none
module secs_top
  import secs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_hsync,
  input wire logic i_clamp,
  input wire logic [7:0] i_embedded_sync_input,
  output logic o_hsync_active,
  output logic o_hsync_lead,
  output logic o_clamp,
  output logic [5:0] o_slicer_threshold,
  output logic o_sliced_sync_output
);
  logic hsync_pol_q;
  logic clamp_sel_q;
  logic clamp_pol_q;
  logic [7:0] clamp_dly_q;
  logic [7:0] clamp_dur_q;
  logic [5:0] thr_q;
  logic [5:0] thr_d;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  logic hs_act_q;
  logic lead_q;
  logic trail_q;
  logic clamp_q;
  logic slice_q;
  logic hs_now;
  logic ext_act;
  logic gen_win;

  // RQ4 RQ8 register writes and reset values
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      hsync_pol_q <= SECS_RST_HSYNC_POL;
      clamp_sel_q <= SECS_RST_CLAMP_SEL;
      clamp_pol_q <= SECS_RST_CLAMP_POL;
      clamp_dly_q <= SECS_RST_CLAMP_DLY;
      clamp_dur_q <= SECS_RST_CLAMP_DUR;
      thr_q <= SECS_RST_THR;
    end else if (i_wr) begin
      if (i_addr == SECS_REG_HSYNC_CFG) begin
        hsync_pol_q <= i_wdata[SECS_BIT_HSYNC_POL];
      end else if (i_addr == SECS_REG_CLAMP_CFG) begin
        clamp_sel_q <= i_wdata[SECS_BIT_CLAMP_SEL];
        clamp_pol_q <= i_wdata[SECS_BIT_CLAMP_POL];
      end else if (i_addr == SECS_REG_CLAMP_DLY) begin
        clamp_dly_q <= i_wdata;
      end else if (i_addr == SECS_REG_CLAMP_DUR) begin
        clamp_dur_q <= i_wdata;
      end else if (i_addr == SECS_REG_SLICE_THR) begin
        thr_q <= thr_d;
      end
    end
  end

  // RQ7 slicer threshold range
  always_comb begin
    thr_d = i_wdata[5:0];
    if (i_wdata[7:6] != 2'b00 || i_wdata[5:0] > SECS_THR_MAX) begin
      thr_d = SECS_THR_MAX;
    end else if (i_wdata[5:0] < SECS_THR_MIN) begin
      thr_d = SECS_THR_MIN;
    end
  end

  // read decode; unmapped offsets read zero
  always_comb begin
    rdata_d = 8'h00;
    if (i_addr == SECS_REG_HSYNC_CFG) begin
      rdata_d[SECS_BIT_HSYNC_POL] = hsync_pol_q;
    end else if (i_addr == SECS_REG_CLAMP_CFG) begin
      rdata_d[SECS_BIT_CLAMP_SEL] = clamp_sel_q;
      rdata_d[SECS_BIT_CLAMP_POL] = clamp_pol_q;
    end else if (i_addr == SECS_REG_CLAMP_DLY) begin
      rdata_d = clamp_dly_q;
    end else if (i_addr == SECS_REG_CLAMP_DUR) begin
      rdata_d = clamp_dur_q;
    end else if (i_addr == SECS_REG_SLICE_THR) begin
      rdata_d = {2'b00, thr_q};
    end else if (i_addr == SECS_REG_STATUS) begin
      rdata_d[SECS_BIT_ST_HSYNC] = hs_act_q;
      rdata_d[SECS_BIT_ST_CLAMP] = clamp_q;
      rdata_d[SECS_BIT_ST_SLICE] = slice_q;
      rdata_d[SECS_BIT_ST_WIN] = gen_win;
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata_q <= 8'h00;
    end else if (i_rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // RQ1 polarity-corrected hsync
  assign hs_now = hsync_pol_q ? i_hsync : !i_hsync;

  // RQ2 RQ3 leading edge output; trailing edge starts the clamp window
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      hs_act_q <= 1'b0;
      lead_q <= 1'b0;
      trail_q <= 1'b0;
    end else begin
      hs_act_q <= hs_now;
      // a polarity flip mid-pulse looks like an edge; software changes it idle
      lead_q <= hs_now && !hs_act_q;
      trail_q <= !hs_now && hs_act_q;
    end
  end

  // RQ5 RQ12 internal window
  secs_clamp_gen u_gen (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_start(trail_q),
    .i_delay(clamp_dly_q),
    .i_duration(clamp_dur_q),
    .o_window(gen_win)
  );

  // RQ6 external clamp sense
  assign ext_act = clamp_pol_q ? i_clamp : !i_clamp;

  // RQ4 RQ5 clamp source select
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      clamp_q <= 1'b0;
    end else begin
      clamp_q <= clamp_sel_q ? ext_act : gen_win;
    end
  end

  // RQ9 noninverting slicer
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      slice_q <= 1'b0;
    end else begin
      // level is in 10 mV steps above the negative peak
      slice_q <= (i_embedded_sync_input > {2'b00, thr_q});
    end
  end

  assign o_rdata = rdata_q;
  assign o_hsync_active = hs_act_q;
  assign o_hsync_lead = lead_q;
  assign o_clamp = clamp_q;
  assign o_slicer_threshold = thr_q;
  assign o_sliced_sync_output = slice_q;

  property p_pol_sense;
    @(posedge i_clk) disable iff (!i_reset_n)
    ($past(i_reset_n) && hsync_pol_q == $past(hsync_pol_q))
      |-> o_hsync_active == ($past(i_hsync) ~^ hsync_pol_q);
  endproperty
  a_pol_sense: assert property (p_pol_sense) else $error("hsync sense wrong"); // RQ1

  property p_no_trail_lead;
    @(posedge i_clk) disable iff (!i_reset_n)
    (!hs_now && hs_act_q) |=> !o_hsync_lead ##1 (!o_hsync_lead || $past(hs_now));
  endproperty
  a_no_trail_lead: assert property (p_no_trail_lead) else $error("trailing edge used"); // RQ2

  property p_fall_lead;
    @(posedge i_clk) disable iff (!i_reset_n)
    (!hsync_pol_q && $past(!hsync_pol_q) && $fell(i_hsync)) |=> o_hsync_lead;
  endproperty
  a_fall_lead: assert property (p_fall_lead) else $error("falling edge missed"); // RQ3

  property p_sel_reset;
    @(posedge i_clk) disable iff (!i_reset_n)
    $rose(i_reset_n) |-> !clamp_sel_q;
  endproperty
  a_sel_reset: assert property (p_sel_reset) else $error("clamp select not 0"); // RQ4

  property p_internal;
    @(posedge i_clk) disable iff (!i_reset_n)
    !clamp_sel_q |=> o_clamp == $past(gen_win);
  endproperty
  a_internal: assert property (p_internal) else $error("internal clamp not used"); // RQ5

  property p_ext_pol;
    @(posedge i_clk) disable iff (!i_reset_n)
    (clamp_sel_q && !clamp_pol_q && !i_clamp) |=> o_clamp;
  endproperty
  a_ext_pol: assert property (p_ext_pol) else $error("clamp sense wrong"); // RQ6

  property p_thr_range;
    @(posedge i_clk) disable iff (!i_reset_n)
    o_slicer_threshold >= SECS_THR_MIN && o_slicer_threshold <= SECS_THR_MAX;
  endproperty
  a_thr_range: assert property (p_thr_range) else $error("threshold out of range"); // RQ7

  property p_thr_reset;
    @(posedge i_clk) disable iff (!i_reset_n)
    $rose(i_reset_n) |-> o_slicer_threshold == SECS_RST_THR;
  endproperty
  a_thr_reset: assert property (p_thr_reset) else $error("threshold reset wrong"); // RQ8

  property p_slice;
    @(posedge i_clk) disable iff (!i_reset_n)
    ({2'b00, o_slicer_threshold} < i_embedded_sync_input && !(i_wr && i_addr == SECS_REG_SLICE_THR))
      |=> o_sliced_sync_output;
  endproperty
  a_slice: assert property (p_slice) else $error("slicer output wrong"); // RQ9

  property p_trail_start;
    @(posedge i_clk) disable iff (!i_reset_n)
    (!clamp_sel_q && trail_q && clamp_dly_q == 8'h00 && clamp_dur_q != 8'h00) ##1 !clamp_sel_q
      |=> o_clamp;
  endproperty
  a_trail_start: assert property (p_trail_start) else $error("window not from trailing edge"); // RQ12

  property p_lead_pulse;
    @(posedge i_clk) disable iff (!i_reset_n)
    o_hsync_lead |=> !o_hsync_lead;
  endproperty
  a_lead_pulse: assert property (p_lead_pulse) else $error("lead pulse too long"); // RQ2

  property p_rise_lead;
    @(posedge i_clk) disable iff (!i_reset_n)
    (hsync_pol_q && $past(hsync_pol_q) && $rose(i_hsync))
      |=> o_hsync_lead;
  endproperty
  a_rise_lead: assert property (p_rise_lead) else $error("rising edge missed"); // RQ3

  property p_ext_high;
    @(posedge i_clk) disable iff (!i_reset_n)
    (clamp_sel_q && clamp_pol_q && i_clamp) |=> o_clamp;
  endproperty
  a_ext_high: assert property (p_ext_high) else $error("active high clamp missed"); // RQ6

  property p_ext_ignored;
    @(posedge i_clk) disable iff (!i_reset_n)
    (!clamp_sel_q && !gen_win && i_clamp) |=> !o_clamp;
  endproperty
  a_ext_ignored: assert property (p_ext_ignored) else $error("clamp input not ignored"); // RQ4

  property p_hs_read;
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_rd && i_addr == SECS_REG_HSYNC_CFG)
      |=> o_rdata[SECS_BIT_HSYNC_POL] == $past(hsync_pol_q);
  endproperty
  a_hs_read: assert property (p_hs_read) else $error("hsync polarity read wrong"); // RQ1

  property p_sel_read;
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_rd && i_addr == SECS_REG_CLAMP_CFG)
      |=> o_rdata[SECS_BIT_CLAMP_SEL] == $past(clamp_sel_q);
  endproperty
  a_sel_read: assert property (p_sel_read) else $error("clamp select read wrong"); // RQ4

  property p_thr_min;
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_wr && i_addr == SECS_REG_SLICE_THR && i_wdata == 8'h00)
      |=> o_slicer_threshold == SECS_THR_MIN;
  endproperty
  a_thr_min: assert property (p_thr_min) else $error("threshold zero not raised"); // RQ7

  property p_thr_keep;
    @(posedge i_clk) disable iff (!i_reset_n)
    !(i_wr && i_addr == SECS_REG_SLICE_THR) |=> $stable(o_slicer_threshold);
  endproperty
  a_thr_keep: assert property (p_thr_keep) else $error("threshold changed unwritten"); // RQ8

  property p_slice_low;
    @(posedge i_clk) disable iff (!i_reset_n)
    ({2'b00, o_slicer_threshold} >= i_embedded_sync_input) |=> !o_sliced_sync_output;
  endproperty
  a_slice_low: assert property (p_slice_low) else $error("slicer high below threshold"); // RQ9

  c_lead: cover property (@(posedge i_clk) disable iff (!i_reset_n) o_hsync_lead);
  c_ext: cover property (@(posedge i_clk) disable iff (!i_reset_n) clamp_sel_q && o_clamp);
  c_int: cover property (@(posedge i_clk) disable iff (!i_reset_n) !clamp_sel_q && o_clamp);
  c_slice: cover property (@(posedge i_clk) disable iff (!i_reset_n) $rose(o_sliced_sync_output));
endmodule : secs_top
`default_nettype wire

/* verification/secs_src_model.sv */
// graphics source model: hsync pulses and an optional clamp strobe
// assumes the bench changes period, width and polarities only while stopped
`default_nettype none
module secs_src_model
  import secs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_run,
  input wire logic i_pol,
  input wire logic i_cl_en,
  input wire logic i_cl_pol,
  input wire logic [3:0] i_width,
  input wire logic [7:0] i_period,
  output logic o_hsync,
  output logic o_clamp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_q;
  logic bp;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_q <= 8'h00;
    end else if (!i_run || cnt_q == i_period - 8'h01) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  // sync active for the first width counts, idle level when stopped
  assign o_hsync = (i_run && cnt_q < {4'h0, i_width}) ? i_pol : !i_pol;
  assign bp = i_run && cnt_q >= {4'h0, i_width} + 8'h02 && cnt_q < {4'h0, i_width} + 8'h08;
  assign o_clamp = !i_cl_en ? 1'h0 : (bp ? i_cl_pol : !i_cl_pol);
endmodule : secs_src_model
`default_nettype wire

/* verification/secs_top_tb.sv */
// bench for secs_top: register port, hsync edges, clamp window and slicer
// assumes secs_src_model drives hsync and clamp; a monitor compares each cycle
`default_nettype none
module secs_top_tb;
  import secs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, rst_n = 1'h0, wr = 1'h0, rd = 1'h0, run = 1'h0, chk = 1'h0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, emb = 8'h00, prd = 8'h30, rdata, e1;
  logic [3:0] wid = 4'h4;
  logic pol = 1'h1, sel = 1'h0, cpol = 1'h1, cl_en = 1'h0, hold = 1'h0;
  logic hs, cl, act, lead, clo, sl, h1, h2, c1;
  logic [5:0] thr, thr_e = 6'h0f;
  logic [7:0] d_e = 8'h00, n_e = 8'h00;
  logic [7:0] tv [8] = '{8'h00, 8'h01, 8'h0f, 8'h21, 8'h22, 8'hff, 8'h0a, 8'h40};
  int num_errors = 0, checked = 0, t = 1000;
  integer seed = 32'h5cef;
  always #20 clk = ~clk;
  secs_top dut_u (.i_clk(clk), .i_reset_n(rst_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_hsync(hs), .i_clamp(cl),
    .i_embedded_sync_input(emb), .o_hsync_active(act), .o_hsync_lead(lead),
    .o_clamp(clo), .o_slicer_threshold(thr), .o_sliced_sync_output(sl));
  secs_src_model src_u (.i_clk(clk), .i_reset_n(rst_n), .i_run(run), .i_pol(pol),
    .i_cl_en(cl_en), .i_cl_pol(cpol), .i_width(wid), .i_period(prd), .o_hsync(hs),
    .o_clamp(cl));
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  function automatic logic [5:0] thr_of(input logic [7:0] v);
    if (v > 8'h21) return SECS_THR_MAX;
    return (v == 8'h00) ? SECS_THR_MIN : v[5:0];
  endfunction : thr_of
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    @(negedge clk);
    cmp("rdata", e, rdata);
  endtask : rd_chk
  // stop the source, program one setting, let stray events settle, then run
  task automatic cfg(input int i);
    logic [7:0] d;
    logic [7:0] n;
    chk <= 1'h0;
    run <= 1'h0;
    repeat (40) @(posedge clk);
    d = (i == 0) ? 8'h00 : 8'({$random(seed)} % 16);
    n = (i == 3) ? 8'h00 : 8'({$random(seed)} % 16);
    pol <= i[0];
    sel <= i[1];
    cpol <= i[2];
    cl_en <= (i != 0);
    wid <= 4'(1 + {$random(seed)} % 8);
    wr_reg(SECS_REG_HSYNC_CFG, {1'h0, i[0], 6'h00});
    wr_reg(SECS_REG_CLAMP_CFG, {i[1], i[2], 6'h00});
    wr_reg(SECS_REG_CLAMP_DLY, d);
    wr_reg(SECS_REG_CLAMP_DUR, n);
    wr_reg(SECS_REG_SLICE_THR, tv[i]);
    rd_chk(SECS_REG_CLAMP_CFG, {i[1], i[2], 6'h00});
    rd_chk(SECS_REG_SLICE_THR, {2'h0, thr_of(tv[i])});
    d_e = d;
    n_e = n;
    thr_e = thr_of(tv[i]);
    repeat (40) @(posedge clk);
    chk <= 1'h1;
    run <= 1'h1;
    repeat (200) @(posedge clk);
  endtask : cfg
  always @(posedge clk) begin : mon
    logic cur;
    logic ex;
    int off;
    emb <= hold ? 8'hff : 8'({$random(seed)} % 40);
    cur = pol ? hs : !hs;
    // t is one behind the edge that sampled the trailing edge
    off = int'(d_e) + 2;
    ex = sel ? (cpol ? c1 : !c1) : (t >= off && t < off + int'(n_e));
    if (chk && rst_n) begin
      cmp("hsync_active", 8'(h1), 8'(act));
      cmp("hsync_lead", 8'(h1 & !h2), 8'(lead));
      cmp("clamp", 8'(ex), 8'(clo));
      cmp("threshold", 8'(thr_e), 8'(thr));
      cmp("sliced", 8'(e1 > 8'(thr_e)), 8'(sl));
    end
    h2 = h1;
    h1 = cur;
    c1 = cl;
    e1 = emb;
    if (h2 && !h1) t = 0;
    else if (t < 1000) t++;
  end
  task automatic report_and_stop;
    if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  initial begin
    #400000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    @(negedge clk);
    cmp("thr_reset", 8'h0f, 8'(thr));
    rd_chk(SECS_REG_HSYNC_CFG, 8'h40);
    rd_chk(SECS_REG_CLAMP_CFG, 8'h40);
    rd_chk(SECS_REG_CLAMP_DLY, 8'h08);
    rd_chk(SECS_REG_CLAMP_DUR, 8'h14);
    rd_chk(SECS_REG_SLICE_THR, 8'h0f);
    wr_reg(8'h33, 8'hff);
    rd_chk(8'h33, 8'h00);
    wr_reg(SECS_REG_HSYNC_CFG, 8'hff);
    rd_chk(SECS_REG_HSYNC_CFG, 8'h40);
    hold <= 1'h1;
    wr_reg(SECS_REG_HSYNC_CFG, 8'h00);
    rd_chk(SECS_REG_STATUS, 8'h05);
    wr_reg(SECS_REG_HSYNC_CFG, 8'h40);
    repeat (12) @(posedge clk);
    rd_chk(SECS_REG_STATUS, 8'h0e);
    hold <= 1'h0;
    for (int i = 0; i < 8; i++) cfg(i);
    chk <= 1'h0;
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    @(negedge clk);
    cmp("thr_reset", 8'h0f, 8'(thr));
    rd_chk(SECS_REG_CLAMP_CFG, 8'h40);
    report_and_stop();
  end
endmodule : secs_top_tb
`default_nettype wire
